// >>> hw/logrd_defines.svh
`ifndef LOGRD_DEFINES_SVH
`define LOGRD_DEFINES_SVH
// Command opcode
`define OPC_LOG_READ      8'h2f
// Log addresses
`define LA_DIRECTORY      8'h00
`define LA_ERROR_LOG      8'h03
`define LA_SELFTEST_LOG   8'h07
`define LA_QUEUED_ERR     8'h10
`define LA_PHY_EVENTS     8'h11
`define LA_HOST_FIRST     8'h80
`define LA_HOST_LAST      8'h9f
// Page lengths in sectors
`define LEN_SINGLE        16'h0001
`define LEN_HOST          16'h0010
// Sector layout
`define IDX_LAST          9'h1ff
`define IDX_INDEX         9'h002
`define DIR_VERSION       8'h01
`define LOG_VERSION       8'h01
// Error log layout
`define EL_ENTRY_BASE     9'h004
`define EL_ENTRY_END      9'h1f4
`define EL_ENTRY_LEN      9'h07c
`define EL_COUNT_LO       9'h1f4
`define EL_COUNT_HI       9'h1f5
`define EL_ERRREG         7'h5b
`define EL_STATREG        7'h65
`define EL_SLOTS          3'h4
`define EL_COUNT_MAX      16'hffff
// Self-test log layout
`define ST_ENTRY_BASE     9'h004
`define ST_ENTRY_END      9'h1f2
`define ST_ENTRY_LEN      9'h01a
`define ST_SLOTS          5'h13
`define ST_NUMBER         5'h00
`define ST_STATUS         5'h01
`define ST_LBA_FIRST      5'h05
`define ST_LBA_LAST       5'h0a
`endif

// >>> hw/logrd_pkg.sv
package logrd_pkg;
   // Command sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_SEND} seq_state_e;
endpackage

// >>> hw/log_page_read_handler.sv
// Behaviour
// R1: Opcode 2Fh selects the log read
// R2: Interrupt once per transferred data block
// R3: Page 11h with reset bit clears counters
// R4: Sector count: current low, previous high
// R5: Data starts at requested starting sector
// R6: Log address low byte, start in mid
// R7: Decode pages 00h,03h,07h,10h,11h read-only
// R8: Host pages 80h-9Fh are 16 sectors
// R9: Abort unsupported, disabled or invalid requests
// R10: Directory version word reads 0001h
// R11: Directory count per address at twice address
// R12: Faulty-command errors never enter error log
// R13: Error log sector layout fixed offsets
// R14: Error log version byte is 01h
// R15: Index names latest entry, zero if none
// R16: Self-test log holds 48/28-bit entries
// R17: Four error entries form a ring
// R18: Device error count saturates at maximum
// R19: Checksum makes sector byte sum zero
// R20: One sector per block, then complete
`timescale 1ns/100ps
`include "logrd_defines.svh"
module log_page_read_handler
   import logrd_pkg::*;
(
   input  wire logic        CLK_SYS,        // System clock, 50 MHz
   input  wire logic        RST_B,          // Async reset, active low
   input  wire logic        CMD_VALID,      // Command block written, one pulse
   input  wire logic [7:0]  CMD_OPCODE,     // Command register
   input  wire logic [7:0]  FEAT_CUR,       // Feature, current write
   input  wire logic [7:0]  COUNT_CUR,      // Sector count, current write
   input  wire logic [7:0]  COUNT_PREV,     // Sector count, previous write
   input  wire logic [7:0]  LOG_ADDR,       // Low address byte, current
   input  wire logic [7:0]  START_CUR,      // Mid address byte, current
   input  wire logic [7:0]  START_PREV,     // Mid address byte, previous
   input  wire logic        SMART_ERR_EN,   // Error logging feature on
   input  wire logic        SELFTEST_EN,    // Self-test feature on
   input  wire logic        NCQ_EN,         // Queued command feature on
   input  wire logic        PHY_EVT_EN,     // Phy event feature on
   input  wire logic        SMART_EN,       // Smart feature on, host pages
   input  wire logic        ERR_EVENT,      // Device error reported, pulse
   input  wire logic        ERR_FAULTY,     // Error came from faulty command
   input  wire logic [7:0]  ERR_REG,        // Error register at event
   input  wire logic [7:0]  ERR_STAT,       // Status register at event
   input  wire logic        ST_EVENT,       // Self-test finished, pulse
   input  wire logic        ST_ADDR28,      // Entry uses 28-bit addressing
   input  wire logic [7:0]  ST_NUM,         // Self-test number
   input  wire logic [7:0]  ST_RESULT,      // Self-test execution status
   input  wire logic [47:0] ST_LBA,         // Failing address
   input  wire logic        DATA_READY,     // Host takes data byte
   output logic             DATA_VALID,     // Data byte valid
   output logic [7:0]       DATA_BYTE,      // Log data byte
   output logic             BUSY,           // Command in progress
   output logic             DRQ,            // Data request status
   output logic             INTRQ,          // Host interrupt pulse
   output logic             CMD_DONE,       // Normal completion pulse
   output logic             CMD_ABORT,      // Aborted completion pulse
   output logic             PHY_CNT_CLR     // Clear phy counters pulse
);
   seq_state_e  state;                      // Sequencer state
   logic [7:0]  page;                       // Selected log address
   logic [15:0] remain;                     // Sectors still to send
   logic [8:0]  idx;                        // Byte offset of DATA_BYTE
   logic [7:0]  sum;                        // Running sector byte sum
   logic        clr_req;                    // Counter reset requested
   logic [7:0]  el_reg  [4];                // Error entry error bytes
   logic [7:0]  el_stat [4];                // Error entry status bytes
   logic [3:0]  el_used;                    // Error entry written
   logic [1:0]  el_wp;                      // Next error slot
   logic [2:0]  el_index;                   // Latest error, 1 based
   logic [15:0] el_count;                   // Lifetime device errors
   logic [7:0]  st_num  [19];               // Self-test numbers
   logic [7:0]  st_res  [19];               // Self-test statuses
   logic [47:0] st_lba  [19];               // Self-test addresses
   logic [4:0]  st_wp;                      // Next self-test slot
   logic [4:0]  st_index;                   // Latest self-test, 1 based
   logic [18:0] st_used;                    // Self-test entry written
   // R4: 16-bit count from two writes
   wire [15:0] req_count = {COUNT_PREV, COUNT_CUR};
   // R6: starting sector from two writes
   wire [15:0] req_start = {START_PREV, START_CUR};
   // R1: single opcode recognised
   wire        is_read   = CMD_VALID && (CMD_OPCODE == `OPC_LOG_READ) && (state == ST_IDLE);
   // R8: host pages range
   wire        is_host   = (LOG_ADDR >= `LA_HOST_FIRST) && (LOG_ADDR <= `LA_HOST_LAST);
   // R7: supported read-only pages and their feature gates
   wire        page_ok   = (LOG_ADDR == `LA_DIRECTORY)
                        || (LOG_ADDR == `LA_ERROR_LOG && SMART_ERR_EN)
                        || (LOG_ADDR == `LA_SELFTEST_LOG && SELFTEST_EN)
                        || (LOG_ADDR == `LA_QUEUED_ERR && NCQ_EN)
                        || (LOG_ADDR == `LA_PHY_EVENTS && PHY_EVT_EN)
                        || (is_host && SMART_EN);
   wire [15:0] page_len  = is_host ? `LEN_HOST : `LEN_SINGLE;
   wire [16:0] req_end   = {1'b0, req_start} + {1'b0, req_count};
   // R9: abort on zero count, overrun or unsupported page
   wire        req_bad   = !page_ok || (req_count == 16'h0000) || (req_end > {1'b0, page_len});
   wire        xfer      = (state == ST_SEND) && DATA_VALID && DATA_READY;
   wire        blk_end   = xfer && (idx == `IDX_LAST);
   wire        last_blk  = blk_end && (remain == 16'h0001);
   // Offset of the byte to fetch next
   wire [8:0]  fetch_idx = is_read ? 9'h000 : (blk_end ? 9'h000 : idx + 9'h001);
   wire [7:0]  fetch_pg  = is_read ? LOG_ADDR : page;
   wire [7:0]  sum_next  = blk_end ? 8'h00 : sum + DATA_BYTE;
   // Error log offset decode; quotients cut to the slot width
   wire [8:0]  el_rel    = fetch_idx - `EL_ENTRY_BASE;
   wire [1:0]  el_slot   = 2'(el_rel / `EL_ENTRY_LEN);
   wire [6:0]  el_off    = 7'(el_rel % `EL_ENTRY_LEN);
   wire        in_el     = (fetch_idx >= `EL_ENTRY_BASE) && (fetch_idx < `EL_ENTRY_END);
   // Self-test log offset decode
   wire [8:0]  st_rel    = fetch_idx - `ST_ENTRY_BASE;
   wire [4:0]  st_slot   = 5'(st_rel / `ST_ENTRY_LEN);
   wire [4:0]  st_off    = 5'(st_rel % `ST_ENTRY_LEN);
   wire        in_st     = (fetch_idx >= `ST_ENTRY_BASE) && (fetch_idx < `ST_ENTRY_END);
   wire [2:0]  lba_sel   = 3'(st_off - `ST_LBA_FIRST);
   wire [7:0]  lba_byte  = st_lba[st_slot][{lba_sel, 3'b000} +: 8];
   // Directory address for this byte pair
   wire [7:0]  dir_addr  = fetch_idx[8:1];
   wire        dir_one   = (dir_addr == `LA_ERROR_LOG) || (dir_addr == `LA_SELFTEST_LOG)
                        || (dir_addr == `LA_QUEUED_ERR) || (dir_addr == `LA_PHY_EVENTS);
   wire        dir_host  = (dir_addr >= `LA_HOST_FIRST) && (dir_addr <= `LA_HOST_LAST);
   // Directory and host pages carry no checksum byte
   wire        has_chk   = (fetch_pg == `LA_ERROR_LOG) || (fetch_pg == `LA_SELFTEST_LOG)
                        || (fetch_pg == `LA_QUEUED_ERR) || (fetch_pg == `LA_PHY_EVENTS);
   // Byte content of the selected page at fetch_idx
   logic [7:0] raw_byte;
   always_comb begin
      raw_byte = 8'h00;
      unique case (fetch_pg)
         `LA_DIRECTORY: begin
            // R10: version word 0001h
            if (fetch_idx == 9'h000) begin
               raw_byte = `DIR_VERSION;
            // R11: low byte at twice address, high byte zero
            end else if (!fetch_idx[0] && dir_one) begin
               raw_byte = 8'(`LEN_SINGLE);
            end else if (!fetch_idx[0] && dir_host) begin
               raw_byte = 8'(`LEN_HOST);
            end
         end
         `LA_ERROR_LOG: begin
            // R13: fixed sector layout
            if (fetch_idx == 9'h000) begin
               // R14: version 01h
               raw_byte = `LOG_VERSION;
            end else if (fetch_idx == `IDX_INDEX) begin
               // R15: latest entry index
               raw_byte = {5'h00, el_index};
            end else if (in_el && el_used[el_slot]) begin
               // R17: unused entries stay zero
               if (el_off == `EL_ERRREG) begin
                  raw_byte = el_reg[el_slot];
               end else if (el_off == `EL_STATREG) begin
                  raw_byte = el_stat[el_slot];
               end
            end else if (fetch_idx == `EL_COUNT_LO) begin
               raw_byte = el_count[7:0];
            end else if (fetch_idx == `EL_COUNT_HI) begin
               raw_byte = el_count[15:8];
            end
         end
         `LA_SELFTEST_LOG: begin
            if (fetch_idx == 9'h000) begin
               raw_byte = `LOG_VERSION;
            end else if (fetch_idx == `IDX_INDEX) begin
               raw_byte = {3'h0, st_index};
            // R16: entries carry full 48-bit address
            end else if (in_st && st_used[st_slot]) begin
               if (st_off == `ST_NUMBER) begin
                  raw_byte = st_num[st_slot];
               end else if (st_off == `ST_STATUS) begin
                  raw_byte = st_res[st_slot];
               end else if (st_off >= `ST_LBA_FIRST && st_off <= `ST_LBA_LAST) begin
                  raw_byte = lba_byte;
               end
            end
         end
         // Queued, phy and host pages read as zero here
         default: raw_byte = 8'h00;
      endcase
   end
   // R19: last byte cancels the running sum
   wire [7:0] chk_byte  = 8'h00 - (sum + DATA_BYTE);
   wire [7:0] next_byte = (has_chk && fetch_idx == `IDX_LAST) ? chk_byte : raw_byte;
   // Command sequencer and transfer
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         state       <= ST_IDLE;
         page        <= 8'h00;
         remain      <= 16'h0000;
         idx         <= 9'h000;
         sum         <= 8'h00;
         clr_req     <= 1'b0;
         DATA_VALID  <= 1'b0;
         DATA_BYTE   <= 8'h00;
         BUSY        <= 1'b0;
         DRQ         <= 1'b0;
         INTRQ       <= 1'b0;
         CMD_DONE    <= 1'b0;
         CMD_ABORT   <= 1'b0;
         PHY_CNT_CLR <= 1'b0;
      end else begin
         INTRQ       <= 1'b0;
         CMD_DONE    <= 1'b0;
         CMD_ABORT   <= 1'b0;
         PHY_CNT_CLR <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               // R9: refuse bad request at once
               if (is_read && req_bad) begin
                  CMD_ABORT <= 1'b1;
               end else if (is_read) begin
                  // R5: byte 0 of the requested start sector
                  state      <= ST_SEND;
                  page       <= LOG_ADDR;
                  remain     <= req_count;
                  idx        <= 9'h000;
                  sum        <= 8'h00;
                  clr_req    <= (LOG_ADDR == `LA_PHY_EVENTS) && FEAT_CUR[0];
                  DATA_BYTE  <= next_byte;
                  DATA_VALID <= 1'b1;
                  BUSY       <= 1'b1;
                  DRQ        <= 1'b1;
                  // R2: interrupt for first block
                  INTRQ      <= 1'b1;
               end
            end
            ST_SEND: begin
               if (last_blk) begin
                  // R20: complete after last sector
                  state       <= ST_IDLE;
                  DATA_VALID  <= 1'b0;
                  DRQ         <= 1'b0;
                  BUSY        <= 1'b0;
                  CMD_DONE    <= 1'b1;
                  // R3: clear counters after they were sent
                  PHY_CNT_CLR <= clr_req;
               end else if (xfer) begin
                  idx       <= fetch_idx;
                  sum       <= sum_next;
                  DATA_BYTE <= next_byte;
                  if (blk_end) begin
                     // R20: one sector per block
                     remain <= remain - 16'h0001;
                     // R2: interrupt for each new block
                     INTRQ  <= 1'b1;
                  end
               end
            end
         endcase
      end
   end
   // Error log ring; faulty-command errors are not counted
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         el_used  <= 4'h0;
         el_wp    <= 2'h0;
         el_index <= 3'h0;
         el_count <= 16'h0000;
         el_reg   <= '{default: 8'h00};
         el_stat  <= '{default: 8'h00};
      // R12: skip errors from faulty commands
      end else if (ERR_EVENT && !ERR_FAULTY) begin
         // R17: overwrite oldest slot
         el_reg[el_wp]  <= ERR_REG;
         el_stat[el_wp] <= ERR_STAT;
         el_used[el_wp] <= 1'b1;
         el_wp          <= el_wp + 2'h1;
         // R15: index of newest entry, 1 to 4
         el_index       <= {1'b0, el_wp} + 3'h1;
         // R18: saturate rather than wrap
         if (el_count != `EL_COUNT_MAX) begin
            el_count <= el_count + 16'h0001;
         end
      end
   end
   // Self-test ring; used flags survive the wrap, an index alone would not
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         st_wp    <= 5'h00;
         st_index <= 5'h00;
         st_used  <= 19'h00000;
         st_num   <= '{default: 8'h00};
         st_res   <= '{default: 8'h00};
         st_lba   <= '{default: 48'h0};
      end else if (ST_EVENT) begin
         st_used[st_wp] <= 1'b1;
         st_num[st_wp] <= ST_NUM;
         st_res[st_wp] <= ST_RESULT;
         // R16: 28-bit entries kept with upper bits zero
         st_lba[st_wp] <= ST_ADDR28 ? {20'h00000, ST_LBA[27:0]} : ST_LBA;
         st_wp         <= (st_wp == `ST_SLOTS - 5'h01) ? 5'h00 : st_wp + 5'h01;
         st_index      <= st_wp + 5'h01;
      end
   end
endmodule

// >>> tb/logrd_checker_assertions.sv
`timescale 1ns/100ps
`include "logrd_defines.svh"
module logrd_checker (
   input wire logic       CLK_SYS,     // Clock
   input wire logic       RST_B,       // Reset, active low
   input wire logic       CMD_VALID,   // Command strobe
   input wire logic [7:0] CMD_OPCODE,  // Opcode
   input wire logic       DATA_READY,  // Host accepts
   input wire logic       DATA_VALID,  // Byte offered
   input wire logic [7:0] DATA_BYTE,   // Byte
   input wire logic       BUSY,        // In progress
   input wire logic       DRQ,         // Data request
   input wire logic       INTRQ,       // Block interrupt
   input wire logic       CMD_DONE,    // Completion
   input wire logic       CMD_ABORT,   // Abort
   input wire logic       PHY_CNT_CLR  // Counter clear
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   logic [8:0] taken;  // Bytes taken within the sector
   // Wraps at 512, so zero marks a sector edge
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) taken <= 9'h000;
      else if (DATA_VALID && DATA_READY) taken <= taken + 9'h001;
   end
   chk_start_answer: assert property (CMD_VALID && CMD_OPCODE == `OPC_LOG_READ && !BUSY
      |=> CMD_ABORT || (BUSY && DRQ && DATA_VALID && INTRQ)) else $error("no answer");
   chk_other_opcode: assert property (CMD_VALID && CMD_OPCODE != `OPC_LOG_READ && !BUSY
      |=> !BUSY && !CMD_ABORT) else $error("foreign opcode answered");
   chk_abort_cause: assert property (CMD_ABORT |-> $past(CMD_VALID) && !BUSY)
      else $error("abort without command");
   chk_intrq_pulse: assert property (INTRQ |-> DATA_VALID && taken == 9'h000 ##1 !INTRQ)
      else $error("interrupt off block edge");
   chk_drq_level: assert property (DATA_VALID |-> DRQ && BUSY)
      else $error("data without request");
   chk_byte_hold: assert property (DATA_VALID && !DATA_READY |=> DATA_VALID && $stable(DATA_BYTE))
      else $error("byte dropped");
   chk_done_end: assert property (CMD_DONE |-> !BUSY && !DRQ && $past(taken) == 9'h1ff)
      else $error("done mid sector");
   chk_phy_clear: assert property (PHY_CNT_CLR |-> CMD_DONE)
      else $error("clear without completion");
endmodule
bind log_page_read_handler logrd_checker logrd_checker_i (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
   .CMD_VALID(CMD_VALID), .CMD_OPCODE(CMD_OPCODE), .DATA_READY(DATA_READY),
   .DATA_VALID(DATA_VALID), .DATA_BYTE(DATA_BYTE), .BUSY(BUSY), .DRQ(DRQ), .INTRQ(INTRQ),
   .CMD_DONE(CMD_DONE), .CMD_ABORT(CMD_ABORT), .PHY_CNT_CLR(PHY_CNT_CLR));

// >>> tb/host_sink.sv
`timescale 1ns/100ps
module host_sink (
   input wire logic CLK_SYS,     // Clock
   input wire logic RST_B,       // Reset, active low
   input wire logic SLOW,        // Stall every other pair
   output logic     DATA_READY   // Host accepts byte
);
   logic [1:0] phase;  // Stall pattern
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         phase      <= 2'h0;
         DATA_READY <= 1'b0;
      end else begin
         phase      <= phase + 2'h1;
         DATA_READY <= !SLOW || phase[1];
      end
   end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic CLK_SYS, RST_B, CMD_VALID, ERR_EVENT, ERR_FAULTY, SLOW, DATA_READY;
   logic DATA_VALID, BUSY, DRQ, INTRQ, CMD_DONE, CMD_ABORT, PHY_CNT_CLR;
   logic [7:0]  CMD_OPCODE, FEAT_CUR, COUNT_CUR, COUNT_PREV, LOG_ADDR, START_CUR, START_PREV;
   logic [7:0]  ERR_REG, ERR_STAT, DATA_BYTE, el_idx;
   logic [4:0]  en;           // Feature enables
   logic [15:0] el_cnt;       // Expected error count
   logic        ST_EVENT, ST_ADDR28;
   logic [7:0]  ST_NUM, ST_RESULT, st_idx, st_n[2], st_r[2];
   logic [47:0] ST_LBA, st_l[2];
   logic [7:0]  el_reg[4], el_stat[4];
   logic [9:0]  notes[$];     // Expected results, kind and data
   logic [7:0]  pg[5] = '{8'h03, 8'h07, 8'h10, 8'h11, 8'h80};
   int n_mismatch, n_compared, cyc, k;
   integer seed = 32'h5609;
   log_page_read_handler log_page_read_handler_i (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
      .CMD_VALID(CMD_VALID), .CMD_OPCODE(CMD_OPCODE), .FEAT_CUR(FEAT_CUR),
      .COUNT_CUR(COUNT_CUR), .COUNT_PREV(COUNT_PREV), .LOG_ADDR(LOG_ADDR),
      .START_CUR(START_CUR), .START_PREV(START_PREV), .SMART_ERR_EN(en[0]),
      .SELFTEST_EN(en[1]), .NCQ_EN(en[2]), .PHY_EVT_EN(en[3]), .SMART_EN(en[4]),
      .ERR_EVENT(ERR_EVENT), .ERR_FAULTY(ERR_FAULTY), .ERR_REG(ERR_REG), .ERR_STAT(ERR_STAT),
      .ST_EVENT(ST_EVENT), .ST_ADDR28(ST_ADDR28), .ST_NUM(ST_NUM), .ST_RESULT(ST_RESULT),
      .ST_LBA(ST_LBA), .DATA_READY(DATA_READY), .DATA_VALID(DATA_VALID), .DATA_BYTE(DATA_BYTE),
      .BUSY(BUSY), .DRQ(DRQ), .INTRQ(INTRQ), .CMD_DONE(CMD_DONE), .CMD_ABORT(CMD_ABORT),
      .PHY_CNT_CLR(PHY_CNT_CLR));
   host_sink host_sink_i (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .SLOW(SLOW),
      .DATA_READY(DATA_READY));
   // Verdict and end of run
   task close_out;
      if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Oldest note against what appeared
   task chk(input logic [1:0] kd, input logic [7:0] d);
      logic [9:0] n;
      n = (notes.size() > 0) ? notes.pop_front() : 10'h3ff;
      n_compared++;
      if ({kd, d} !== n) begin
         n_mismatch++;
         $display("Error result expected %h seen %h", n, {kd, d});
      end
   endtask
   // Expected page byte; checksum is patched by the caller
   function automatic logic [7:0] exp_byte(input logic [7:0] la, input int i);
      exp_byte = 8'h00;
      if (la == 8'h00) begin
         if (i == 0 || i == 6 || i == 14 || i == 32 || i == 34) exp_byte = 8'h01;
         if (i >= 256 && i < 320 && i % 2 == 0) exp_byte = 8'h10;
      end else if (la == 8'h03 || la == 8'h07) begin
         if (i == 0) exp_byte = 8'h01;
         if (la == 8'h03) begin
            if (i == 2) exp_byte = el_idx;
            if (i == 500) exp_byte = el_cnt[7:0];
            if (i == 501) exp_byte = el_cnt[15:8];
            for (int s = 0; s < 4; s++) begin
               if (i == 4 + 124 * s + 91) exp_byte = el_reg[s];
               if (i == 4 + 124 * s + 101) exp_byte = el_stat[s];
            end
         end else begin
            // index, then number, status and address of each entry
            if (i == 2) exp_byte = st_idx;
            for (int s = 0; s < 2; s++) begin
               if (s < st_idx && i == 4 + 26 * s) exp_byte = st_n[s];
               if (s < st_idx && i == 5 + 26 * s) exp_byte = st_r[s];
               for (int j = 0; j < 6; j++) begin
                  if (s < st_idx && i == 9 + 26 * s + j) exp_byte = st_l[s][8 * j +: 8];
               end
            end
         end
      end
   endfunction
   // Issue one log read and note what must come back
   task automatic run(input logic [7:0] la, input logic [15:0] cnt, st,
                      input logic [7:0] ft, input logic ab);
      logic [7:0] b, sum;
      if (ab) notes.push_back(10'h200);
      else begin
         for (int s = 0; s < cnt; s++) begin
            notes.push_back(10'h300);
            sum = 8'h00;
            for (int i = 0; i < 512; i++) begin
               b = exp_byte(la, i);
               if (i == 511 && la inside {8'h03, 8'h07, 8'h10, 8'h11}) b = 8'h00 - sum;
               sum = sum + b;
               notes.push_back({2'h0, b});
            end
         end
         notes.push_back({2'h1, 7'h00, la == 8'h11 && ft[0]});
      end
      @(posedge CLK_SYS);
      CMD_VALID  <= 1'b1;
      CMD_OPCODE <= 8'h2f;
      LOG_ADDR   <= la;
      // count and start split over two writes
      {COUNT_PREV, COUNT_CUR} <= cnt;
      {START_PREV, START_CUR} <= st;
      FEAT_CUR   <= ft;
      SLOW       <= 1'($random(seed));
      @(posedge CLK_SYS);
      CMD_VALID <= 1'b0;
      while (notes.size() > 0 || BUSY !== 1'b0) @(posedge CLK_SYS);
   endtask
   // Report a device error; faulty ones stay out of the log
   task log_err(input logic f);
      @(posedge CLK_SYS);
      ERR_EVENT  <= 1'b1;
      ERR_FAULTY <= f;
      ERR_REG    <= 8'($random(seed));
      ERR_STAT   <= 8'($random(seed));
      @(posedge CLK_SYS);
      ERR_EVENT <= 1'b0;
      if (!f) begin
         el_idx = (el_idx == 8'h04) ? 8'h01 : el_idx + 8'h01;
         el_reg[el_idx - 1]  = ERR_REG;
         el_stat[el_idx - 1] = ERR_STAT;
         el_cnt++;
      end
   endtask
   // Finish one self-test; a 28-bit entry has no address bits above 27
   task log_st(input logic a28);
      @(posedge CLK_SYS);
      ST_EVENT  <= 1'b1;
      ST_ADDR28 <= a28;
      ST_NUM    <= 8'($random(seed));
      ST_RESULT <= 8'($random(seed));
      ST_LBA    <= {16'($random(seed)), 32'($random(seed))};
      @(posedge CLK_SYS);
      ST_EVENT <= 1'b0;
      st_n[st_idx] = ST_NUM;
      st_r[st_idx] = ST_RESULT;
      st_l[st_idx] = a28 ? {20'h00000, ST_LBA[27:0]} : ST_LBA;
      st_idx++;
   endtask
   // Result watcher, one note per event
   always @(posedge CLK_SYS) begin
      if (RST_B) begin
         if (INTRQ) chk(2'h3, 8'h00);
         if (DATA_VALID && DATA_READY) chk(2'h0, DATA_BYTE);
         if (CMD_DONE) chk(2'h1, {7'h00, PHY_CNT_CLR});
         if (CMD_ABORT) chk(2'h2, 8'h00);
      end
      cyc++;
      if (cyc == 80000) begin
         n_mismatch++;
         close_out;
      end
   end
   initial begin
      CLK_SYS = 0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end
   initial begin
      {RST_B, CMD_VALID, ERR_EVENT, ERR_FAULTY, SLOW} = 5'h00;
      {CMD_OPCODE, FEAT_CUR, COUNT_CUR, COUNT_PREV, LOG_ADDR} = 40'h0;
      {START_CUR, START_PREV, ERR_REG, ERR_STAT, el_idx} = 40'h0;
      en = 5'h1f;
      {ST_EVENT, ST_ADDR28, ST_NUM, ST_RESULT, st_idx} = 26'h0;
      ST_LBA = 48'h0;
      el_cnt = 16'h0000;
      el_reg = '{4{8'h00}};
      el_stat = '{4{8'h00}};
      repeat (4) @(posedge CLK_SYS);
      RST_B <= 1'b1;
      run(8'h00, 16'h0001, 16'h0000, 8'h00, 1'b0);
      run(8'h03, 16'h0001, 16'h0000, 8'h00, 1'b0);
      log_err(1'b1);
      for (k = 0; k < 5; k++) log_err(1'b0);
      run(8'h03, 16'h0001, 16'h0000, 8'h00, 1'b0);
      log_st(1'b1);
      log_st(1'b0);
      run(8'h07, 16'h0001, 16'h0000, 8'h00, 1'b0);
      run(8'h10, 16'h0001, 16'h0000, 8'h00, 1'b0);
      run(8'h11, 16'h0001, 16'h0000, 8'h01, 1'b0);
      run(8'h11, 16'h0001, 16'h0000, 8'h00, 1'b0);
      run(8'h9f, 16'h0002, 16'h000e, 8'h00, 1'b0);
      run(8'h03, 16'h0000, 16'h0000, 8'h00, 1'b1);
      run(8'h03, 16'h0001, 16'h0001, 8'h00, 1'b1);
      run(8'h05, 16'h0001, 16'h0000, 8'h00, 1'b1);
      run(8'h80, 16'h0002, 16'h000f, 8'h00, 1'b1);
      for (k = 0; k < 5; k++) begin
         en <= ~(5'h01 << k);
         run(pg[k], 16'h0001, 16'h0000, 8'h00, 1'b1);
      end
      en <= 5'h1f;
      @(posedge CLK_SYS);
      CMD_VALID  <= 1'b1;
      CMD_OPCODE <= 8'h2e;
      @(posedge CLK_SYS);
      CMD_VALID <= 1'b0;
      repeat (3) @(posedge CLK_SYS);
      n_compared++;
      // foreign opcode leaves the handler idle
      if (BUSY !== 1'b0) begin
         n_mismatch++;
         $display("Error BUSY expected 0 seen %b", BUSY);
      end
      close_out;
   end
endmodule
